// File: core/ssc_pkg.sv
// Purpose: Constants for the switch status and control register pair
// Assumes: AXI4-Lite byte addresses, 32-bit data, one aligned word per register
// Notes:   Field positions, marker/merge/lock reset values and the default reset pulse length live here
//
// Overview of operation
// - Operating mode pins give a read-only 3-bit field; 0 normal, 1 with EEPROM.
// - Downstream common-clock strap captured at fundamental reset, status bit 5.
// - Upstream common-clock strap captured at fundamental reset, status bit 6.
// - Master serial-bus slow-mode strap captured at fundamental reset, status bit 7.
// - Reference clock mode strap captured at fundamental reset, status bit 8.
// - Reset-halt strap captured at fundamental reset, status bit 9.
// - Three port-pair merge straps captured into bits 12 to 14, reset zero.
// - Live upstream lock state in bits 22:20; zero unlocked, N locked port N.
// - Four-bit software marker, read-write, reset zero, survives hot reset.
// - Writing one to control bit 0 starts fundamental reset; zero does nothing.
// - Control bit 0 always reads as zero.
// - Write response for the triggering write goes out before reset starts.
// - While reset-halt control bit is set, switch logic stays in reset.
package ssc_pkg;
    localparam logic [11:0] SWITCH_STATUS_OFS  = 12'h400;
    localparam logic [11:0] SWITCH_CONTROL_OFS = 12'h404;

    // Status field positions
    localparam int MODE_LSB        = 0;
    localparam int MODE_W          = 3;
    localparam int CCLK_DS_BIT     = 5;
    localparam int CCLK_US_BIT     = 6;
    localparam int MSER_SLOW_BIT   = 7;
    localparam int REFCLK_MODE_BIT = 8;
    localparam int RST_HALT_BIT    = 9;
    localparam int MERGE_LSB       = 12;
    localparam int MERGE_W         = 3;
    localparam int LOCK_LSB        = 20;
    localparam int LOCK_W          = 3;
    localparam int MARKER_LSB      = 28;
    localparam int MARKER_W        = 4;

    // Control field positions
    localparam int FUNDAMENTAL_RESET_TRIGGER_TRIG_BIT   = 0;
    localparam int HALT_CTL_BIT    = 2;

    // Reset values
    localparam logic [MARKER_W-1:0] MARKER_RST = 4'h0;
    localparam logic [MERGE_W-1:0]  MERGE_RST  = 3'h0;
    localparam logic [LOCK_W-1:0]   LOCK_RST   = 3'h0;

    // Strap vector layout: mode, five single straps, merges
    localparam int STRAP_W = 11;

    // Self-initiated fundamental reset pulse length
    localparam int FUNDAMENTAL_RESET_TRIGGER_CYCLES = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: core/ssc_regs.sv
// Purpose: Switch status and control registers behind an AXI4-Lite slave
// Assumes: Straps are asynchronous pins; lock state is from this clock domain
// Notes:   A self fundamental reset re-captures straps and clears sticky state
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ssc_regs
    import ssc_pkg::*;
#(
    parameter int ADDR_W   = 12,
    parameter int FUNDAMENTAL_RESET_TRIGGER_LEN = FUNDAMENTAL_RESET_TRIGGER_CYCLES
) (
    input  wire logic              i_clk,           // 250 MHz clock
    input  wire logic              i_rstn,          // Fundamental reset, low
    input  wire logic [2:0]        i_mode_pins,     // Operating mode pins
    input  wire logic              i_cclk_ds,       // Downstream common clock
    input  wire logic              i_cclk_us,       // Upstream common clock
    input  wire logic              i_mser_slow,     // Master serial slow mode
    input  wire logic              i_refclk_mode,   // Reference clock mode
    input  wire logic              i_rst_halt,      // Reset halt strap
    input  wire logic [2:0]        i_merge,         // Merge 0/1, 2/3, 4/5
    input  wire logic [2:0]        i_lock_state,    // Live upstream lock
    input  wire logic [ADDR_W-1:0] i_awaddr,        // Write address
    input  wire logic              i_awvalid,       // Write address valid
    output logic                   o_awready,       // Write address ready
    input  wire logic [31:0]       i_wdata,         // Write data
    input  wire logic [3:0]        i_wstrb,         // Write strobes
    input  wire logic              i_wvalid,        // Write data valid
    output logic                   o_wready,        // Write data ready
    output logic [1:0]             o_bresp,         // Write response
    output logic                   o_bvalid,        // Write response valid
    input  wire logic              i_bready,        // Write response ready
    input  wire logic [ADDR_W-1:0] i_araddr,        // Read address
    input  wire logic              i_arvalid,       // Read address valid
    output logic                   o_arready,       // Read address ready
    output logic [31:0]            o_rdata,         // Read data
    output logic [1:0]             o_rresp,         // Read response
    output logic                   o_rvalid,        // Read data valid
    input  wire logic              i_rready,        // Read data ready
    output logic                   o_fund_reset,    // Self fundamental reset
    output logic                   o_core_halt      // Hold switch logic
);

    initial begin
        if (ADDR_W < 11 || ADDR_W > 32) begin
            $error("ssc_regs: ADDR_W must be 11 to 32");
        end
        if (FUNDAMENTAL_RESET_TRIGGER_LEN < 1 || FUNDAMENTAL_RESET_TRIGGER_LEN > 65535) begin
            $error("ssc_regs: FUNDAMENTAL_RESET_TRIGGER_LEN must be 1 to 65535");
        end
    end

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    logic [STRAP_W-1:0] strap_pin;
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap_s3;
    logic [STRAP_W-1:0] strap_flt;

    assign strap_pin = {i_merge, i_rst_halt, i_refclk_mode, i_mser_slow,
                        i_cclk_us, i_cclk_ds, i_mode_pins};

    // Free running so pins settle while reset is held
    genvar g;
    generate
        for (g = 0; g < STRAP_W; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                strap_s1[g] <= strap_pin[g];
                strap_s2[g] <= strap_s1[g];
                strap_s3[g] <= strap_s2[g];
                if (strap_s2[g] == strap_s3[g]) begin
                    strap_flt[g] <= strap_s3[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Fundamental reset tracking
    // ------------------------------------------------------------
    logic        fundamental_reset_trigger_busy;
    logic [15:0] fundamental_reset_trigger_cnt;
    logic        fundamental_reset_trigger_pend;
    logic        in_fundamental_reset_trigger;
    logic        in_fundamental_reset_trigger_q;
    logic        capture;
    logic        b_done;
    logic        wr_go;
    logic        wr_hit_ctl;
    logic        wr_hit_sts;
    logic [31:0] i_wdata_q;
    logic [3:0]  i_wstrb_q;
    logic [1:0]  settle;
    logic        strap_ok;

    assign in_fundamental_reset_trigger  = fundamental_reset_trigger_busy;
    assign strap_ok = settle == 2'h3;
    assign capture  = in_fundamental_reset_trigger_q && !in_fundamental_reset_trigger && strap_ok;

    // Capture waits until the strap filter holds settled values
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            settle <= 2'h0;
        end else if (!strap_ok) begin
            settle <= settle + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            in_fundamental_reset_trigger_q <= 1'b1;
        end else if (!in_fundamental_reset_trigger_q || strap_ok) begin
            in_fundamental_reset_trigger_q <= in_fundamental_reset_trigger;
        end
    end

    // Trigger waits for its own write response
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            fundamental_reset_trigger_pend <= 1'b0;
        end else if (wr_go && wr_hit_ctl && i_wstrb_q[0]
                     && i_wdata_q[FUNDAMENTAL_RESET_TRIGGER_TRIG_BIT]) begin
            fundamental_reset_trigger_pend <= 1'b1;
        end else if (b_done) begin
            fundamental_reset_trigger_pend <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            fundamental_reset_trigger_busy <= 1'b0;
            fundamental_reset_trigger_cnt  <= 16'h0000;
        end else if (fundamental_reset_trigger_pend && b_done) begin
            fundamental_reset_trigger_busy <= 1'b1;
            fundamental_reset_trigger_cnt  <= 16'(FUNDAMENTAL_RESET_TRIGGER_LEN - 1);
        end else if (fundamental_reset_trigger_busy) begin
            if (fundamental_reset_trigger_cnt == 16'h0000) begin
                fundamental_reset_trigger_busy <= 1'b0;
            end else begin
                fundamental_reset_trigger_cnt <= fundamental_reset_trigger_cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_fund_reset <= 1'b0;
        end else begin
            o_fund_reset <= (fundamental_reset_trigger_pend && b_done) || (fundamental_reset_trigger_busy && fundamental_reset_trigger_cnt != 16'h0000);
        end
    end

    // ------------------------------------------------------------
    // Captured straps
    // ------------------------------------------------------------
    logic [MODE_W-1:0]  mode_fld;
    logic [4:0]         single_fld;
    logic [MERGE_W-1:0] merge_fld;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_fld   <= 3'h0;
            single_fld <= 5'h00;
            merge_fld  <= MERGE_RST;
        end else if (capture) begin
            mode_fld   <= strap_flt[2:0];
            single_fld <= strap_flt[7:3];
            merge_fld  <= strap_flt[10:8];
        end
    end

    // ------------------------------------------------------------
    // Writable state and registered lock input
    // ------------------------------------------------------------
    logic [MARKER_W-1:0] marker;
    logic [LOCK_W-1:0]   lock_q;

    always_ff @(posedge i_clk) begin
        if (!i_rstn || in_fundamental_reset_trigger) begin
            marker <= MARKER_RST;
        end else if (wr_go && wr_hit_sts && i_wstrb_q[3]) begin
            marker <= i_wdata_q[MARKER_LSB +: MARKER_W];
        end
    end

    // Halt control loads from the strap at the end of fundamental reset
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_core_halt <= 1'b0;
        end else if (capture) begin
            o_core_halt <= strap_flt[7];
        end else if (wr_go && wr_hit_ctl && i_wstrb_q[0]) begin
            o_core_halt <= i_wdata_q[HALT_CTL_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lock_q <= LOCK_RST;
        end else begin
            lock_q <= i_lock_state;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_have;
    logic              w_have;

    assign wr_go      = aw_have && w_have && !o_bvalid;
    assign wr_hit_sts = awaddr_q == ADDR_W'(SWITCH_STATUS_OFS);
    assign wr_hit_ctl = awaddr_q == ADDR_W'(SWITCH_CONTROL_OFS);
    assign b_done     = o_bvalid && i_bready;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aw_have   <= 1'b0;
            o_awready <= 1'b1;
            awaddr_q  <= '0;
        end else if (o_awready && i_awvalid) begin
            aw_have   <= 1'b1;
            o_awready <= 1'b0;
            awaddr_q  <= i_awaddr;
        end else if (b_done) begin
            aw_have   <= 1'b0;
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            w_have    <= 1'b0;
            o_wready  <= 1'b1;
            i_wdata_q <= 32'h00000000;
            i_wstrb_q <= 4'h0;
        end else if (o_wready && i_wvalid) begin
            w_have    <= 1'b1;
            o_wready  <= 1'b0;
            i_wdata_q <= i_wdata;
            i_wstrb_q <= i_wstrb;
        end else if (b_done) begin
            w_have    <= 1'b0;
            o_wready  <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_hit_sts || wr_hit_ctl) ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            o_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] sts_word;
    logic [31:0] ctl_word;

    always_comb begin
        sts_word = 32'h00000000;
        sts_word[MODE_LSB +: MODE_W]     = mode_fld;
        sts_word[CCLK_DS_BIT]            = single_fld[0];
        sts_word[CCLK_US_BIT]            = single_fld[1];
        sts_word[MSER_SLOW_BIT]          = single_fld[2];
        sts_word[REFCLK_MODE_BIT]        = single_fld[3];
        sts_word[RST_HALT_BIT]           = single_fld[4];
        sts_word[MERGE_LSB +: MERGE_W]   = merge_fld;
        sts_word[LOCK_LSB +: LOCK_W]     = lock_q;
        sts_word[MARKER_LSB +: MARKER_W] = marker;
    end

    always_comb begin
        ctl_word = 32'h00000000;
        ctl_word[FUNDAMENTAL_RESET_TRIGGER_TRIG_BIT] = 1'b0;
        ctl_word[HALT_CTL_BIT]  = o_core_halt;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            if (i_araddr == ADDR_W'(SWITCH_STATUS_OFS)) begin
                o_rdata <= sts_word;
                o_rresp <= RESP_OKAY;
            end else if (i_araddr == ADDR_W'(SWITCH_CONTROL_OFS)) begin
                o_rdata <= ctl_word;
                o_rresp <= RESP_OKAY;
            end else begin
                o_rdata <= 32'h00000000;
                o_rresp <= RESP_SLVERR;
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// File: sim/ssc_regs_chk.sv
// Purpose: Assertions on the switch status and control register ports
// Assumes: Bound into ssc_regs, sees only its ports
// Notes:   Last taken read address judges the read data
`timescale 1ns/1ns
`default_nettype none
module ssc_regs_chk
    import ssc_pkg::*;
#(
    parameter int ADDR_W   = 12,
    parameter int FUNDAMENTAL_RESET_TRIGGER_LEN = FUNDAMENTAL_RESET_TRIGGER_CYCLES
) (
    input wire logic              i_clk,        // Clock
    input wire logic              i_rstn,       // Reset
    input wire logic [ADDR_W-1:0] i_araddr,     // Read addr
    input wire logic              i_arvalid,    // AR valid
    input wire logic              o_arready,    // AR ready
    input wire logic [31:0]       o_rdata,      // Read data
    input wire logic [1:0]        o_rresp,      // Read resp
    input wire logic              o_rvalid,     // R valid
    input wire logic              i_rready,     // R ready
    input wire logic              o_awready,    // AW ready
    input wire logic              o_wready,     // W ready
    input wire logic [1:0]        o_bresp,      // Write resp
    input wire logic              o_bvalid,     // B valid
    input wire logic              i_bready,     // B ready
    input wire logic              o_fund_reset  // Self reset
);
    logic [11:0] rd_addr;
    logic [15:0] hi_cnt;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) rd_addr <= 12'h0;
        else if (i_arvalid && o_arready) rd_addr <= i_araddr[11:0];
    end

    // Length of the self reset pulse
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !o_fund_reset) hi_cnt <= 16'h0;
        else hi_cnt <= hi_cnt + 16'h1;
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    chk_b_hold:
        assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    chk_r_hold:
        assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    chk_b_busy:
        assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken during response");
    chk_r_busy:
        assert property (o_rvalid |-> !o_arready)
        else $error("read taken during response");
    chk_fundamental_reset_trigger_after_b:
        assert property ($rose(o_fund_reset) |-> $past(o_bvalid) && $past(i_bready))
        else $error("self reset before completion");
    chk_fundamental_reset_trigger_len:
        assert property ($fell(o_fund_reset) |-> hi_cnt == 16'(FUNDAMENTAL_RESET_TRIGGER_LEN))
        else $error("self reset length wrong");
    chk_ctl_zero:
        assert property (o_rvalid && rd_addr == SWITCH_CONTROL_OFS |-> !o_rdata[0])
        else $error("trigger bit read as one");
    chk_rsvd_zero:
        assert property (o_rvalid && rd_addr == SWITCH_STATUS_OFS
            |-> (o_rdata & 32'h0f8f8c18) == 32'h0)
        else $error("reserved status bits set");
    chk_bad_addr:
        assert property (o_rvalid && rd_addr != SWITCH_STATUS_OFS
            && rd_addr != SWITCH_CONTROL_OFS
            |-> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind ssc_regs ssc_regs_chk #(.ADDR_W(ADDR_W), .FUNDAMENTAL_RESET_TRIGGER_LEN(FUNDAMENTAL_RESET_TRIGGER_LEN)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .o_fund_reset(o_fund_reset));
`default_nettype wire

// File: sim/ssc_regs_tb.sv
// Purpose: Self-checking bench for the switch status and control registers
// Assumes: AXI4-Lite master tasks, straps held steady around captures
// Notes:   Self reset shortened to 4 cycles
`timescale 1ns/1ns
`default_nettype none
module ssc_regs_tb
    import ssc_pkg::*;
;
    logic        clk, rstn, cds, cus, slow, refm, halt, awv, wv, bready, arv, rready;
    logic        awrdy, wrdy, bv, arrdy, rv, fundamental_reset_trigger, chalt;
    logic [2:0]  mode, merge, lock;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [11:0] bad [2] = '{12'h408, 12'h3fc};
    int          miscompares, comparisons, cycles, n;

    ssc_regs #(.FUNDAMENTAL_RESET_TRIGGER_LEN(4)) DUT (
        .i_clk(clk), .i_rstn(rstn), .i_mode_pins(mode), .i_cclk_ds(cds),
        .i_cclk_us(cus), .i_mser_slow(slow), .i_refclk_mode(refm), .i_rst_halt(halt),
        .i_merge(merge), .i_lock_state(lock), .i_awaddr(awaddr), .i_awvalid(awv),
        .o_awready(awrdy), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arv), .o_arready(arrdy), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rready), .o_fund_reset(fundamental_reset_trigger),
        .o_core_halt(chalt));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (!bv);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arrdy) arv <= 1'b0;
        end while (!rv);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {rstn, awv, wv, bready, arv, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {mode, cds, cus, slow, refm, halt, merge, lock} = {3'h1, 5'h15, 3'h5, 3'h5};
        {miscompares, comparisons, cycles} = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(12'h400);
        chk(rd, 32'h005052a1);
        chk(32'(chalt), 32'h1);
        rd_reg(12'h404);
        chk(rd, 32'h4);
        $display("test straps done");
        lock <= 3'h2;
        wr(12'h400, 32'hffffffff, 4'hf);
        chk(32'(resp), 32'h0);
        rd_reg(12'h400);
        chk(rd, 32'hf02052a1);
        $display("test marker done");
        wr(12'h404, 32'h0, 4'h1);
        repeat (3) @(posedge clk);
        chk({30'h0, fundamental_reset_trigger, chalt}, 32'h0);
        rd_reg(12'h404);
        chk(rd, 32'h0);
        $display("test control done");
        foreach (bad[i]) begin
            wr(bad[i], 32'hffffffff, 4'hf);
            chk(32'(resp), 32'h2);
            rd_reg(bad[i]);
            chk({rd[31:2], resp}, 32'h2);
        end
        $display("test unmapped done");
        {mode, cds, cus, slow, refm, halt, merge, lock} <= {3'h0, 5'h0b, 3'h2, 3'h0};
        wr(12'h404, 32'h1, 4'h1);
        chk({30'h0, resp}, {31'h0, fundamental_reset_trigger});
        n = 0;
        while (!fundamental_reset_trigger && n < 4) begin
            @(posedge clk);
            n++;
        end
        chk(32'(fundamental_reset_trigger), 32'h1);
        while (fundamental_reset_trigger) @(posedge clk);
        repeat (10) @(posedge clk);
        rd_reg(12'h400);
        chk(rd, 32'h00002340);
        rd_reg(12'h404);
        chk({rd[31:1], chalt}, 32'h5);
        $display("test self reset done");
        summarize();
    end
endmodule
`default_nettype wire
